// ==== dv/testbench.sv ====
// Self-checking bench for the timer 2 counter
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  tmr2_pkg::tmr2_sfr_s sfrReq;
  logic [7:0]          sfrRdata, d, c;
  logic                bitWrite = 1'b0, bitValue = 1'b0;
  logic [2:0]          bitIndex = 3'h0;
  logic                extPin = 1'b1, trigPin = 1'b1;
  logic                intEn = 1'b1, t1Ovf = 1'b0;
  logic                intReq, rxBaud, txBaud;
  logic [15:0]         v, r;
  logic [31:0]         seed = 32'h148b5;
  int                  fail_count = 0, n_checks = 0, rxN = 0, txN = 0, i;
  tmr2_counter tmr2_counter_inst (.clk(clk), .rst(rst), .sfrReq(sfrReq),
    .sfrRdata(sfrRdata), .bitWrite(bitWrite), .bitIndex(bitIndex),
    .bitValue(bitValue), .externalCountPin(extPin),
    .triggerPin(trigPin), .timer2IntEnable(intEn),
    .timer1Overflow(t1Ovf), .timer2IntRequest(intReq),
    .receiveBaudClock(rxBaud), .transmitBaudClock(txBaud));
  tmr2_cpu tmr2_cpu_inst (.clk(clk), .sfrReq(sfrReq), .sfrRdata(sfrRdata));
  // Clock and baud pulse counters
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (rxBaud === 1'b1) rxN <= rxN + 1;
    if (txBaud === 1'b1) txN <= txN + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    tmr2_cpu_inst.wr(a, x);
  endtask
  task automatic cc(input logic [7:0] a, input logic [7:0] e);
    tmr2_cpu_inst.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  // Word access, low byte at a, high byte at a+1
  task automatic ww(input logic [7:0] a, input logic [15:0] x);
    wr(a, x[7:0]);
    wr(a + 8'h01, x[15:8]);
  endtask
  task automatic rw(input logic [7:0] a, output logic [15:0] x);
    tmr2_cpu_inst.rd(a, x[7:0]);
    tmr2_cpu_inst.rd(a + 8'h01, x[15:8]);
  endtask
  task automatic bw(input logic [2:0] b, input logic x);
    @(negedge clk);
    bitWrite = 1'b1;
    bitIndex = b;
    bitValue = x;
    @(negedge clk);
    bitWrite = 1'b0;
  endtask
  // One falling edge on the trigger or the count pin
  task automatic fall(input logic t);
    @(negedge clk);
    if (t) trigPin = 1'b0;
    else extPin = 1'b0;
    repeat (6) @(negedge clk);
    trigPin = 1'b1;
    extPin = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  // Watchdog
  initial begin
    #500000;
    fail_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (i = 200; i < 207; i++) cc(i[7:0], 8'h00);
    wr(8'hc9, 8'hff);
    cc(8'hc9, 8'h03);
    wr(8'hc9, 8'h00);
    bw(3'h3, 1'b1);
    cc(8'hc8, 8'h08);
    $display("test registers done");
    seed = xs(seed);
    r = seed[15:0];
    ww(8'hca, r);
    rw(8'hca, v);
    chk(v, r);
    ww(8'hcc, 16'hffff);
    wr(8'hc8, 8'h04);
    for (i = 0; i < 40 && intReq !== 1'b1; i++) @(negedge clk);
    bw(3'h2, 1'b0);
    chk(intReq, 1'b1);
    cc(8'hc8, 8'h80);
    repeat (30) @(negedge clk);
    rw(8'hcc, v);
    chk(v, r);
    bw(3'h7, 1'b0);
    cc(8'hc8, 8'h00);
    chk(intReq, 1'b0);
    $display("test overflow done");
    ww(8'hcc, 16'hffff);
    wr(8'hc8, 8'h35);
    for (i = 0; i < 40 && rxBaud !== 1'b1; i++) @(negedge clk);
    bw(3'h2, 1'b0);
    cc(8'hc8, 8'h31);
    rw(8'hcc, v);
    chk(v, r);
    chk(rxN[15:0], 16'h0001);
    chk(txN[15:0], 16'h0001);
    wr(8'hc8, 8'h00);
    t1Ovf = 1'b1;
    @(negedge clk);
    t1Ovf = 1'b0;
    repeat (3) @(negedge clk);
    chk(rxN[15:0], 16'h0002);
    chk(txN[15:0], 16'h0002);
    $display("test baud done");
    seed = xs(seed);
    v = seed[15:0];
    ww(8'hcc, v);
    wr(8'hc8, 8'h09);
    fall(1'b1);
    rw(8'hca, r);
    chk(r, v);
    cc(8'hc8, 8'h49);
    chk(intReq, 1'b1);
    intEn = 1'b0;
    repeat (2) @(negedge clk);
    chk(intReq, 1'b0);
    intEn = 1'b1;
    wr(8'hc9, 8'h01);
    @(negedge clk);
    chk(intReq, 1'b0);
    wr(8'hc9, 8'h00);
    for (i = 0; i < 2; i++) begin
      c = (i == 0) ? 8'h01 : 8'h39;
      ww(8'hcc, ~v);
      wr(8'hc8, c);
      fall(1'b1);
      rw(8'hca, r);
      chk(r, v);
      cc(8'hc8, c);
    end
    wr(8'hc8, 8'h08);
    fall(1'b1);
    rw(8'hcc, r);
    chk(r, v);
    $display("test trigger done");
    ww(8'hcc, 16'h0000);
    wr(8'hc8, 8'h06);
    seed = xs(seed);
    for (i = 0; i < 3 + seed[1:0]; i++) fall(1'b0);
    bw(3'h2, 1'b0);
    rw(8'hcc, v);
    chk(v, 16'h0003 + seed[1:0]);
    ww(8'hcc, 16'hffff);
    wr(8'hc8, 8'h07);
    fall(1'b0);
    bw(3'h2, 1'b0);
    rw(8'hcc, v);
    chk(v, 16'h0000);
    cc(8'hc8, 8'h83);
    $display("test event count done");
    end_sim();
  end
endmodule
`default_nettype wire

// ==== dv/tmr2_cpu.sv ====
// Core model issuing register-space accesses
`timescale 1ns/100ps
`default_nettype none
module tmr2_cpu (
  input  wire logic                clk,
  output var  tmr2_pkg::tmr2_sfr_s sfrReq,
  input  wire logic [7:0]          sfrRdata
);
  initial sfrReq = '0;
  // Byte write, held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk);
    sfrReq = '{1'b1, 1'b0, a, x};
    @(negedge clk);
    sfrReq.write = 1'b0;
  endtask
  // Byte read, data registered one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(negedge clk);
    sfrReq.addr = a;
    @(negedge clk);
    x = sfrRdata;
  endtask
endmodule
`default_nettype wire

// ==== verilog/tmr2_counter.sv ====
// Timer 2 capture/reload counter with its register block
// Summary of operation
// - Overflow sets bit 7 flag; only software clears it.
// - Overflow flag is not set while either baud select is high.
// - Trigger edge capture or reload with enable sets bit 6 flag.
// - With timer 2 interrupt enabled, external flag requests the vector.
// - With down-count enable high, external flag raises no interrupt.
// - Bit 5 high: receive baud uses timer 2 overflows, else timer 1.
// - Bit 4 high: transmit baud uses timer 2 overflows, else timer 1.
// - Bit 3 enables trigger edges unless timer 2 clocks the serial port.
// - Counter runs only while bit 2 run control is high.
// - Bit 1 picks internal ticks or external pin falling edges.
// - Capture mode with enable copies count on trigger falling edges.
// - Reload mode reloads on overflow and enabled trigger edges.
// - Any baud select forces auto-reload on overflow.
// - A byte pair holds captured or reload value.
// - Control register at 0c8h, bit-addressable, resets to zero.
`timescale 1ns/100ps
`default_nettype none
`include "tmr2_params.svh"
module tmr2_counter (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire tmr2_pkg::tmr2_sfr_s sfrReq,
  output logic [7:0]             sfrRdata,
  input  wire logic              bitWrite,
  input  wire logic [2:0]        bitIndex,
  input  wire logic              bitValue,
  input  wire logic              externalCountPin,
  input  wire logic              triggerPin,
  input  wire logic              timer2IntEnable,
  input  wire logic              timer1Overflow,
  output logic                   timer2IntRequest,
  output logic                   receiveBaudClock,
  output logic                   transmitBaudClock
);
  tmr2_pkg::tmr2_ctrl_s ctrl;
  logic [7:0]  modeReg;
  logic [7:0]  capLow;
  logic [7:0]  capHigh;
  logic [7:0]  countLow;
  logic [7:0]  countHigh;
  logic [15:0] count;
  logic [3:0]  tickDiv;
  logic        tick;
  logic        cntMeta, cntSync, cntLast;
  logic        trgMeta, trgSync, trgLast;
  logic        cntFall, trgFall;
  logic        baudMode, step, overflow, trigEvent;
  logic        doCapture, doReload;
  logic [15:0] next_count;
  logic [7:0]  next_ctrlByte;
  logic        wrCtrl;
  logic [7:0]  ctrlByte;

  // Decode a register address match on a write
  // The strobe is an argument so that continuous users see it change
  function automatic logic hit(input tmr2_pkg::tmr2_sfr_s q,
                               input logic [7:0]          b);
    hit = q.write && (q.addr == b);
  endfunction

  // Machine-cycle tick from the core clock
  always_ff @(posedge clk) begin
    if (rst || tickDiv == `TMR2_TICK_DIV) begin
      tickDiv <= 4'h0;
    end else begin
      tickDiv <= tickDiv + 4'h1;
    end
  end
  assign tick = (tickDiv == `TMR2_TICK_DIV);

  // Two-stage synchronisers and edge history for the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      cntMeta <= 1'b1;
      cntSync <= 1'b1;
      cntLast <= 1'b1;
      trgMeta <= 1'b1;
      trgSync <= 1'b1;
      trgLast <= 1'b1;
    end else begin
      cntMeta <= externalCountPin;
      cntSync <= cntMeta;
      cntLast <= cntSync;
      trgMeta <= triggerPin;
      trgSync <= trgMeta;
      trgLast <= trgSync;
    end
  end
  assign cntFall = cntLast && !cntSync;
  assign trgFall = trgLast && !trgSync;

  // Counting and event conditions
  assign count     = {countHigh, countLow};
  assign baudMode  = ctrl.receiveBaudSelect || ctrl.transmitBaudSelect;
  assign step      = ctrl.runControl &&
                     (ctrl.counterTimerSelect ? cntFall : tick);
  assign overflow  = step && (count == 16'hffff);
  assign trigEvent = trgFall && ctrl.triggerEnable && !baudMode;
  assign doCapture = trigEvent && ctrl.captureReloadSelect;
  assign doReload  = overflow && (baudMode || !ctrl.captureReloadSelect)
                   || trigEvent && !ctrl.captureReloadSelect;

  // Next counter value
  always_comb begin
    next_count = count;
    if (doReload) begin
      next_count = {capHigh, capLow};
    end else if (step) begin
      next_count = count + 16'h0001;
    end
  end

  // Counter bytes: software writes, else hardware update
  always_ff @(posedge clk) begin
    if (rst) begin
      countLow  <= `TMR2_RESET_BYTE;
      countHigh <= `TMR2_RESET_BYTE;
    end else begin
      countLow  <= next_count[7:0];
      countHigh <= next_count[15:8];
      if (hit(sfrReq, `TMR2_ADDR_COUNT_LOW)) begin
        countLow <= sfrReq.wdata;
      end
      if (hit(sfrReq, `TMR2_ADDR_COUNT_HIGH)) begin
        countHigh <= sfrReq.wdata;
      end
    end
  end

  // Capture/reload pair: capture wins over software write
  always_ff @(posedge clk) begin
    if (rst) begin
      capLow  <= `TMR2_RESET_BYTE;
      capHigh <= `TMR2_RESET_BYTE;
    end else if (doCapture) begin
      capLow  <= countLow;
      capHigh <= countHigh;
    end else begin
      if (hit(sfrReq, `TMR2_ADDR_CAP_LOW)) begin
        capLow <= sfrReq.wdata;
      end
      if (hit(sfrReq, `TMR2_ADDR_CAP_HIGH)) begin
        capHigh <= sfrReq.wdata;
      end
    end
  end

  // Mode register keeps only its two implemented bits
  always_ff @(posedge clk) begin
    if (rst) begin
      modeReg <= `TMR2_RESET_BYTE;
    end else if (hit(sfrReq, `TMR2_ADDR_MODE)) begin
      modeReg <= sfrReq.wdata & `TMR2_MODE_MASK;
    end
  end

  // Byte or single-bit write to the control register
  assign wrCtrl = hit(sfrReq, `TMR2_ADDR_CONTROL) || bitWrite;
  assign ctrlByte = ctrl;
  always_comb begin
    next_ctrlByte = ctrl;
    if (hit(sfrReq, `TMR2_ADDR_CONTROL)) begin
      next_ctrlByte = sfrReq.wdata;
    end else if (bitWrite) begin
      next_ctrlByte[bitIndex] = bitValue;
    end
  end

  // Control register; hardware set wins over software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= tmr2_pkg::tmr2_ctrl_s'(`TMR2_RESET_BYTE);
    end else begin
      if (wrCtrl) begin
        ctrl <= tmr2_pkg::tmr2_ctrl_s'(next_ctrlByte);
      end
      if (overflow && !baudMode) begin
        ctrl.overflowFlag <= 1'b1;
      end
      if (trigEvent) begin
        ctrl.externalTriggerFlag <= 1'b1;
      end
    end
  end

  // Read data multiplexer, unmapped reads give zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sfrRdata <= 8'h00;
    end else begin
      unique case (sfrReq.addr)
        `TMR2_ADDR_CONTROL:    sfrRdata <= ctrl;
        `TMR2_ADDR_MODE:       sfrRdata <= modeReg;
        `TMR2_ADDR_CAP_LOW:    sfrRdata <= capLow;
        `TMR2_ADDR_CAP_HIGH:   sfrRdata <= capHigh;
        `TMR2_ADDR_COUNT_LOW:  sfrRdata <= countLow;
        `TMR2_ADDR_COUNT_HIGH: sfrRdata <= countHigh;
        default:               sfrRdata <= 8'h00;
      endcase
    end
  end

  // Interrupt request and baud clock selection
  always_ff @(posedge clk) begin
    if (rst) begin
      timer2IntRequest  <= 1'b0;
      receiveBaudClock  <= 1'b0;
      transmitBaudClock <= 1'b0;
    end else begin
      timer2IntRequest  <= timer2IntEnable && (ctrl.overflowFlag ||
        ctrl.externalTriggerFlag && !modeReg[`TMR2_BIT_DOWN_COUNT_ENABLE]);
      receiveBaudClock  <= ctrl.receiveBaudSelect ? overflow
                                                  : timer1Overflow;
      transmitBaudClock <= ctrl.transmitBaudSelect ? overflow
                                                   : timer1Overflow;
    end
  end

  // Named steps shared by the checks
  sequence trigSeen_q;
    trigEvent;
  endsequence
  sequence ovfReload_q;
    overflow && (baudMode || !ctrl.captureReloadSelect) && !sfrReq.write;
  endsequence
  sequence trigReload_q;
    trigEvent && !ctrl.captureReloadSelect && !sfrReq.write;
  endsequence

  // Flag setting and holding
  ovf_flag_set_a: assert property (
    @(posedge clk) disable iff (rst)
    overflow && !baudMode |=> ctrl.overflowFlag)
    else $error("overflow flag not set");
  ovf_flag_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    ctrl.overflowFlag && !wrCtrl |=> ctrl.overflowFlag)
    else $error("overflow flag cleared by hardware");
  ovf_flag_baud_a: assert property (
    @(posedge clk) disable iff (rst)
    baudMode && !wrCtrl && !$past(ctrl.overflowFlag) && !ctrl.overflowFlag
    |=> !ctrl.overflowFlag || $past(wrCtrl))
    else $error("overflow flag set in baud mode");
  ext_flag_set_a: assert property (
    @(posedge clk) disable iff (rst)
    trigSeen_q |=> ctrl.externalTriggerFlag)
    else $error("external flag not set");
  ext_flag_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    ctrl.externalTriggerFlag && !wrCtrl |=> ctrl.externalTriggerFlag)
    else $error("external flag cleared by hardware");
  ext_flag_cause_a: assert property (
    @(posedge clk) disable iff (rst)
    !ctrl.externalTriggerFlag && !trigEvent && !wrCtrl
    |=> !ctrl.externalTriggerFlag)
    else $error("external flag set without trigger");

  // Interrupt request
  int_request_a: assert property (
    @(posedge clk) disable iff (rst)
    timer2IntEnable && ctrl.externalTriggerFlag && !modeReg[0]
    |=> timer2IntRequest)
    else $error("interrupt not requested");
  int_disabled_a: assert property (
    @(posedge clk) disable iff (rst)
    !timer2IntEnable |=> !timer2IntRequest)
    else $error("interrupt requested while disabled");
  int_updown_a: assert property (
    @(posedge clk) disable iff (rst)
    !ctrl.overflowFlag && modeReg[0] |=> !timer2IntRequest)
    else $error("external flag interrupted in up/down mode");

  // Baud clock sources
  rx_baud_a: assert property (
    @(posedge clk) disable iff (rst)
    ctrl.receiveBaudSelect |=> receiveBaudClock == $past(overflow))
    else $error("receive baud source wrong");
  rx_timer1_a: assert property (
    @(posedge clk) disable iff (rst)
    !ctrl.receiveBaudSelect |=> receiveBaudClock == $past(timer1Overflow))
    else $error("receive baud not from timer 1");
  tx_baud_a: assert property (
    @(posedge clk) disable iff (rst)
    !ctrl.transmitBaudSelect |=> transmitBaudClock == $past(timer1Overflow))
    else $error("transmit baud source wrong");
  tx_timer2_a: assert property (
    @(posedge clk) disable iff (rst)
    ctrl.transmitBaudSelect |=> transmitBaudClock == $past(overflow))
    else $error("transmit baud not from timer 2");

  // Trigger pin gating
  trig_ignored_a: assert property (
    @(posedge clk) disable iff (rst)
    trgFall && !ctrl.triggerEnable && !sfrReq.write
    |=> $stable({capHigh, capLow}))
    else $error("disabled trigger changed capture pair");
  trig_baud_a: assert property (
    @(posedge clk) disable iff (rst)
    trgFall && baudMode && !wrCtrl && !ctrl.externalTriggerFlag
    |=> !ctrl.externalTriggerFlag)
    else $error("trigger acted in baud mode");

  // Counting source and run control
  halt_count_a: assert property (
    @(posedge clk) disable iff (rst)
    !ctrl.runControl && !sfrReq.write && !trigEvent
    |=> $stable(count))
    else $error("counter moved while halted");
  count_step_a: assert property (
    @(posedge clk) disable iff (rst)
    step && !doReload && !sfrReq.write
    |=> count == $past(count) + 16'h0001)
    else $error("counter did not advance");
  ext_source_a: assert property (
    @(posedge clk) disable iff (rst)
    ctrl.counterTimerSelect && !cntFall && !sfrReq.write && !trigEvent
    |=> $stable(count))
    else $error("event counter moved without pin edge");
  tick_source_a: assert property (
    @(posedge clk) disable iff (rst)
    !ctrl.counterTimerSelect && !tick && !sfrReq.write && !trigEvent
    |=> $stable(count))
    else $error("timer moved without tick");

  // Capture and reload
  capture_copy_a: assert property (
    @(posedge clk) disable iff (rst)
    doCapture |=> {capHigh, capLow} == $past(count))
    else $error("capture value wrong");
  reload_ovf_a: assert property (
    @(posedge clk) disable iff (rst)
    doReload && !sfrReq.write |=> count == $past({capHigh, capLow}))
    else $error("reload value wrong");
  ovf_reload_a: assert property (
    @(posedge clk) disable iff (rst)
    ovfReload_q |=> count == $past({capHigh, capLow}))
    else $error("overflow reload value wrong");
  trig_reload_a: assert property (
    @(posedge clk) disable iff (rst)
    trigReload_q |=> count == $past({capHigh, capLow}))
    else $error("trigger reload value wrong");
  baud_no_capture_a: assert property (
    @(posedge clk) disable iff (rst)
    baudMode && !sfrReq.write |=> $stable({capHigh, capLow}))
    else $error("capture in baud mode");
  capture_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !doCapture && !sfrReq.write
    |=> $stable({capHigh, capLow}))
    else $error("capture pair changed unprompted");

  // Control register reset and bit access, counter rollover
  ctrl_reset_a: assert property (
    @(posedge clk)
    rst |=> ctrlByte == `TMR2_RESET_BYTE)
    else $error("control register not cleared by reset");
  bit_write_a: assert property (
    @(posedge clk) disable iff (rst)
    bitWrite && !sfrReq.write && !overflow && !trgFall
    |=> ctrlByte[$past(bitIndex)] == $past(bitValue))
    else $error("bit write did not land");
  rollover_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    overflow && ctrl.captureReloadSelect && !baudMode && !sfrReq.write
    |=> count == 16'h0000)
    else $error("counter did not roll over to zero");
endmodule
`default_nettype wire

// ==== verilog/tmr2_params.svh ====
// Constants for the timer 2 capture/reload counter
`ifndef TMR2_PARAMS_SVH
`define TMR2_PARAMS_SVH
`define TMR2_ADDR_CONTROL    8'hc8
`define TMR2_ADDR_MODE       8'hc9
`define TMR2_ADDR_CAP_LOW    8'hca
`define TMR2_ADDR_CAP_HIGH   8'hcb
`define TMR2_ADDR_COUNT_LOW  8'hcc
`define TMR2_ADDR_COUNT_HIGH 8'hcd
`define TMR2_BIT_OVF         7
`define TMR2_BIT_EXF         6
`define TMR2_BIT_RXSEL       5
`define TMR2_BIT_TXSEL       4
`define TMR2_BIT_TRIGEN      3
`define TMR2_BIT_RUN         2
`define TMR2_BIT_CTSEL       1
`define TMR2_BIT_CAPSEL      0
`define TMR2_BIT_DOWN_COUNT_ENABLE        0
`define TMR2_RESET_BYTE      8'h00
`define TMR2_MODE_MASK       8'h03
`define TMR2_TICK_DIV        4'hb
`endif

// ==== verilog/tmr2_pkg.sv ====
// Types for the timer 2 capture/reload counter
package tmr2_pkg;
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmr2_sfr_s;
  typedef struct packed {
    logic overflowFlag;
    logic externalTriggerFlag;
    logic receiveBaudSelect;
    logic transmitBaudSelect;
    logic triggerEnable;
    logic runControl;
    logic counterTimerSelect;
    logic captureReloadSelect;
  } tmr2_ctrl_s;
endpackage
